// ===== mor_defines.svh
`ifndef MOR_DEFINES_SVH
`define MOR_DEFINES_SVH

// Command codes and register reset
`define MOR_CMD_RESPONSE_CFG  8'hf8
`define MOR_RESPONSE_RESET    8'hbf
`define MOR_CMD_CLEAR_FAULTS  8'h03

// Field positions
`define MOR_ACT_HI            7
`define MOR_ACT_LO            6
`define MOR_RETRY_HI          5
`define MOR_RETRY_LO          3
`define MOR_DELAY_HI          2
`define MOR_DELAY_LO          0

// Response and retry codes
`define MOR_ACT_IGNORE        2'h0
`define MOR_ACT_SHUTDOWN      2'h2
`define MOR_ACT_HOLD          2'h3
`define MOR_RETRY_NONE        3'h0
`define MOR_RETRY_CONT        3'h7

// Threshold default, release and warning ratios (percent)
`define MOR_THRESH_RESET      16'hc266
`define MOR_RELEASE_PCT       95
`define MOR_WARN_PCT          90

// Retry unit: 35 ms at 100 MHz
`define MOR_CLK_MHZ           100
`define MOR_RETRY_UNIT_MS     35
`define MOR_RETRY_UNIT_CYC    (`MOR_RETRY_UNIT_MS * 1000 * `MOR_CLK_MHZ)

`endif

// ===== mor_pkg.sv
package mor_pkg;
    // Fault handling states
    typedef enum logic [1:0] {
        MOR_RUN     = 2'b00,
        MOR_OFF     = 2'b01,
        MOR_WAIT    = 2'b10,
        MOR_LATCHED = 2'b11
    } mor_state_t;

    typedef logic [7:0]  mor_byte_t;
    typedef logic [15:0] mor_word_t;
endpackage : mor_pkg

// ===== mor_monitor_ov.sv
// Overview of operation
// - One-byte global read/write response register at command F8h.
// - Response register resets to BFh.
// - Response code 00 ignores the fault; code 01 unused.
// - Active response pulls the alert line low and sets status bit.
// - Status bit stays set until the clear-faults command.
// - Code 10 disables output at once, then follows retry setting.
// - Code 11 holds output off until voltage below 95% of limit.
// - Retry setting 000 keeps output off until faults cleared.
// - Retry setting 111 restarts repeatedly until commanded off or other fault.
// - Each continuous restart waits for voltage below 95% of limit.
// - Restart spacing is (delay field plus one) times 35 ms.
// - Threshold comes from the monitor_overvoltage_threshold input; warning threshold is 90% of it.
`timescale 1ns/1ps
`default_nettype none
`include "mor_defines.svh"

module mor_monitor_ov #(
    parameter int unsigned RETRY_UNIT_CYC = `MOR_RETRY_UNIT_CYC
) (
    input  wire logic              clk_sys,
    input  wire logic              resetn,
    input  wire logic              cmd_wr,
    input  wire mor_pkg::mor_byte_t cmd_code,
    input  wire mor_pkg::mor_byte_t cmd_wdata,
    output logic                   cmd_rdata_valid,
    output mor_pkg::mor_byte_t     cmd_rdata,
    input  wire logic              cmd_rd,
    input  wire mor_pkg::mor_word_t monitor_overvoltage_threshold,
    input  wire mor_pkg::mor_word_t auxiliary_monitor_voltage,
    input  wire logic              meas_update,
    input  wire logic              commanded_on,
    input  wire logic              other_fault_off,
    output logic                   output_enable,
    output logic                   alert_output_line_n,
    output logic                   status_mon_ov_fault,
    output logic                   status_mon_ov_warn
);
    import mor_pkg::*;

    localparam int unsigned CW = $clog2(RETRY_UNIT_CYC * 8 + 1);

    // Magnitude compare with 100%, 95% and 90% scaling (same Linear-11 format)
    function automatic logic above_pct(input mor_word_t v,
                                       input mor_word_t lim,
                                       input logic [6:0] pct);
        logic [22:0] lhs;
        logic [22:0] rhs;
        lhs = 23'(v) * 23'd100;
        rhs = 23'(lim) * 23'(pct);
        return lhs > rhs;
    endfunction : above_pct

    mor_byte_t   cfg_r;
    mor_state_t  state_r;
    mor_state_t  state_nxt;
    logic [CW-1:0] timer_r;
    logic [CW-1:0] timer_nxt;
    logic        fault_r;
    logic        warn_r;
    logic        alert_n_r;
    logic        oe_r;
    logic        rvalid_r;
    mor_byte_t   rdata_r;
    logic        over_r;
    logic        below_r;

    // Field decode
    wire logic [1:0] act   = cfg_r[`MOR_ACT_HI:`MOR_ACT_LO];
    wire logic [2:0] retry = cfg_r[`MOR_RETRY_HI:`MOR_RETRY_LO];
    wire logic [2:0] delay = cfg_r[`MOR_DELAY_HI:`MOR_DELAY_LO];
    wire logic cfg_hit   = cmd_code == `MOR_CMD_RESPONSE_CFG;
    wire logic clr_cmd   = cmd_wr && cmd_code == `MOR_CMD_CLEAR_FAULTS;
    wire logic active    = act == `MOR_ACT_SHUTDOWN || act == `MOR_ACT_HOLD;
    wire logic fault_evt = meas_update && active &&
                           above_pct(auxiliary_monitor_voltage,
                                     monitor_overvoltage_threshold,
                                     7'd100);
    wire logic warn_evt  = meas_update &&
                           above_pct(auxiliary_monitor_voltage,
                                     monitor_overvoltage_threshold,
                                     7'(`MOR_WARN_PCT));
    wire logic [CW-1:0] retry_cyc =
        CW'((32'(delay) + 32'd1) * RETRY_UNIT_CYC);
    wire logic stop = !commanded_on || other_fault_off;

    // Register write and readback
    always_ff @(posedge clk_sys or negedge resetn) begin
        if (!resetn) begin
            cfg_r    <= `MOR_RESPONSE_RESET;
            rvalid_r <= 1'b0;
            rdata_r  <= 8'h00;
        end else begin
            if (cmd_wr && cfg_hit) cfg_r <= cmd_wdata;
            rvalid_r <= cmd_rd && cfg_hit;
            rdata_r  <= (cmd_rd && cfg_hit) ? cfg_r : 8'h00;
        end
    end

    // Sticky status, set wins over clear
    always_ff @(posedge clk_sys or negedge resetn) begin
        if (!resetn) begin
            fault_r <= 1'b0;
            warn_r  <= 1'b0;
            alert_n_r <= 1'b1;
        end else begin
            fault_r <= fault_evt || (fault_r && !clr_cmd);
            warn_r  <= warn_evt || (warn_r && !clr_cmd);
            // Alert kept in flop as active low, so the pin is a flop
            alert_n_r <= !(fault_evt || (!alert_n_r && !clr_cmd));
        end
    end

    // Measurement flags held between updates
    always_ff @(posedge clk_sys or negedge resetn) begin
        if (!resetn) begin
            over_r  <= 1'b0;
            below_r <= 1'b1;
        end else if (meas_update) begin
            over_r  <= above_pct(auxiliary_monitor_voltage,
                                 monitor_overvoltage_threshold, 7'd100);
            below_r <= !above_pct(auxiliary_monitor_voltage,
                                  monitor_overvoltage_threshold,
                                  7'(`MOR_RELEASE_PCT));
        end
    end

    // Response state machine
    always_comb begin
        state_nxt = state_r;
        timer_nxt = (timer_r != '0) ? timer_r - CW'(1) : timer_r;
        case (state_r)
            MOR_RUN: begin
                if (fault_evt) begin
                    state_nxt = (act == `MOR_ACT_HOLD) ? MOR_OFF :
                                (retry == `MOR_RETRY_CONT) ? MOR_WAIT :
                                MOR_LATCHED;
                    // Load one short: zero is the gap's last cycle
                    timer_nxt = retry_cyc - CW'(1);
                end
            end
            MOR_OFF: begin
                if (below_r && !over_r) state_nxt = MOR_RUN;
            end
            MOR_WAIT: begin
                if (stop) state_nxt = MOR_LATCHED;
                else if (timer_r == '0 && below_r) begin
                    state_nxt = MOR_RUN;
                end
            end
            MOR_LATCHED: begin
                if (clr_cmd) state_nxt = MOR_RUN;
            end
            default: state_nxt = MOR_RUN;
        endcase
    end

    // State, timer and output enable
    always_ff @(posedge clk_sys or negedge resetn) begin
        if (!resetn) begin
            state_r <= MOR_RUN;
            timer_r <= '0;
            oe_r    <= 1'b0;
        end else begin
            state_r <= state_nxt;
            timer_r <= timer_nxt;
            oe_r    <= state_nxt == MOR_RUN && commanded_on;
        end
    end

    assign output_enable       = oe_r;
    assign alert_output_line_n = alert_n_r;
    assign status_mon_ov_fault = fault_r;
    assign status_mon_ov_warn  = warn_r;
    assign cmd_rdata_valid     = rvalid_r;
    assign cmd_rdata           = rdata_r;
endmodule : mor_monitor_ov
`default_nettype wire

// ===== mor_host_model.sv
`timescale 1ns/1ps
`default_nettype none
module mor_host_model (
    input  wire logic                clk_sys,
    output logic                     cmd_wr,
    output logic                     cmd_rd,
    output mor_pkg::mor_byte_t       cmd_code,
    output mor_pkg::mor_byte_t       cmd_wdata,
    input  wire logic                cmd_rdata_valid,
    input  wire mor_pkg::mor_byte_t  cmd_rdata
);
    import mor_pkg::*;
    // Idle bus from time zero
    initial begin
        cmd_wr = 1'b0;
        cmd_rd = 1'b0;
        cmd_code = 8'h00;
        cmd_wdata = 8'h00;
    end
    // One strobed byte; released lines show inverted data
    task xfer(input logic rd, input mor_byte_t code, input mor_byte_t data,
              output mor_byte_t rdata, output logic ok);
        @(posedge clk_sys) #1;
        cmd_wr = !rd;
        cmd_rd = rd;
        cmd_code = code;
        cmd_wdata = data;
        @(posedge clk_sys) #1;
        cmd_wr = 1'b0;
        cmd_rd = 1'b0;
        cmd_code = ~code;
        cmd_wdata = ~data;
        ok = cmd_rdata_valid;
        rdata = cmd_rdata;
    endtask : xfer
endmodule : mor_host_model
`default_nettype wire

// ===== mor_monitor_ov_props.sv
`timescale 1ns/1ps
`default_nettype none
module mor_monitor_ov_props #(parameter int unsigned RETRY_UNIT_CYC = 10) (
    input wire logic clk_sys, resetn, cmd_wr, cmd_rd, meas_update,
    input wire logic commanded_on, other_fault_off, output_enable,
    input wire logic alert_output_line_n, status_mon_ov_fault,
    input wire logic status_mon_ov_warn, cmd_rdata_valid,
    input wire mor_pkg::mor_byte_t cmd_code, cmd_wdata, cmd_rdata,
    input wire mor_pkg::mor_word_t monitor_overvoltage_threshold,
    input wire mor_pkg::mor_word_t auxiliary_monitor_voltage
);
    import mor_pkg::*;
    mor_byte_t cfg_r;
    wire hit = meas_update &&
        (auxiliary_monitor_voltage > monitor_overvoltage_threshold);
    wire clr = cmd_wr && (cmd_code == 8'h03);
    // Shadow of the response byte
    always_ff @(posedge clk_sys or negedge resetn)
        if (!resetn) cfg_r <= 8'hbf;
        else if (cmd_wr && cmd_code == 8'hf8) cfg_r <= cmd_wdata;
    default clocking @(posedge clk_sys); endclocking
    default disable iff (!resetn);
    AST_RD_OK: assert property (cmd_rd && cmd_code == 8'hf8 |=>
        cmd_rdata_valid && cmd_rdata == cfg_r) else $error("bad read");
    AST_RD_NO: assert property (cmd_rd && cmd_code != 8'hf8 |=>
        !cmd_rdata_valid) else $error("stray valid");
    AST_STICKY: assert property (status_mon_ov_fault && !clr |=>
        status_mon_ov_fault) else $error("fault bit lost");
    AST_ALERT: assert property (alert_output_line_n ==
        !status_mon_ov_fault) else $error("alert mismatch");
    AST_SET: assert property (hit && cfg_r[7] |=>
        status_mon_ov_fault && !output_enable) else $error("no trip");
    AST_IGN: assert property (hit && !cfg_r[7] && !status_mon_ov_fault
        |=> !status_mon_ov_fault) else $error("ignored fault set bit");
    AST_GAP: assert property (hit && cfg_r[7:6] == 2'b10 |=>
        (!output_enable) [*8]) else $error("restart too soon");
    AST_LATCH: assert property (hit && cfg_r[7:3] == 5'h10 |=>
        !output_enable until clr) else $error("latch released");
    cover property (hit && cfg_r[7:6] == 2'b11);
    cover property (hit && cfg_r[7:3] == 5'h17);
    cover property (clr && status_mon_ov_fault);
endmodule : mor_monitor_ov_props
bind mor_monitor_ov mor_monitor_ov_props
    #(.RETRY_UNIT_CYC(RETRY_UNIT_CYC)) mor_monitor_ov_props_inst (.*);
`default_nettype wire

// ===== test_monitor_ov_fault_response.sv
`timescale 1ns/1ps
`default_nettype none
module test_monitor_ov_fault_response;
    import mor_pkg::*;
    typedef struct packed {mor_byte_t c; mor_word_t v; logic f, e;} mor_row_t;
    localparam mor_word_t HI = 16'h1400;
    localparam mor_word_t LO = 16'h0100;
    logic clk_sys, resetn = 1'b0, meas_update = 1'b0, commanded_on = 1'b1;
    logic other_fault_off = 1'b0, cmd_wr, cmd_rd, cmd_rdata_valid, ok;
    logic output_enable, alert_output_line_n, status_mon_ov_fault;
    logic status_mon_ov_warn;
    mor_byte_t cmd_code, cmd_wdata, cmd_rdata, d;
    mor_word_t monitor_overvoltage_threshold = 16'h1000;
    mor_word_t auxiliary_monitor_voltage = LO;
    int bad_count = 0, checked = 0, n, cycles = 0;
    mor_row_t rows [7] = '{'{8'h00, HI, 1'b0, 1'b1}, '{8'h40, HI, 1'b0, 1'b1},
        '{8'h80, HI, 1'b1, 1'b0}, '{8'h88, HI, 1'b1, 1'b0},
        '{8'hc0, HI, 1'b1, 1'b0}, '{8'hbf, HI, 1'b1, 1'b0},
        '{8'hbf, 16'h1000, 1'b0, 1'b1}};
    mor_monitor_ov #(.RETRY_UNIT_CYC(10)) mor_monitor_ov_inst (.*);
    mor_host_model mor_host_model_inst (.*);
    initial begin
        clk_sys = 1'b0;
        forever #5 clk_sys = ~clk_sys;
    end
    task check(input string nm, input mor_byte_t exp, input mor_byte_t got);
        checked++;
        if (got !== exp) begin
            bad_count++;
            $display("[ERR] %s exp %h got %h", nm, exp, got);
        end
    endtask : check
    task wrap_up;
        if (bad_count == 0 && checked > 0) $display("ALL CHECKS OK");
        else $display("CHECKS NOT OK");
        $finish;
    endtask : wrap_up
    task cmd(input logic rd, input mor_byte_t code, input mor_byte_t data);
        mor_host_model_inst.xfer(rd, code, data, d, ok);
    endtask : cmd
    task meas(input mor_word_t v);
        @(posedge clk_sys) #1;
        meas_update = 1'b1;
        auxiliary_monitor_voltage = v;
        @(posedge clk_sys) #1;
        meas_update = 1'b0;
    endtask : meas
    // Hang guard
    always @(posedge clk_sys) begin
        cycles++;
        if (cycles == 6000) begin
            bad_count++;
            wrap_up();
        end
    end
    initial begin
        repeat (2) @(posedge clk_sys);
        #1 resetn = 1'b1;
        cmd(1'b1, 8'hf8, 8'h00);
        check("reset", 8'hbf, d);
        cmd(1'b1, 8'h20, 8'h00);
        check("refused", 8'h00, 8'(ok));
        for (int i = 0; i < 7; i++) begin
            meas(LO);
            cmd(1'b0, 8'h03, 8'h00);
            cmd(1'b0, 8'hf8, rows[i].c);
            cmd(1'b1, 8'hf8, 8'h00);
            check("rdata", rows[i].c, d);
            repeat (100) @(posedge clk_sys);
            meas(rows[i].v);
            check("fault", 8'(rows[i].f), 8'(status_mon_ov_fault));
            check("alert", 8'(!rows[i].f), 8'(alert_output_line_n));
            check("oe", 8'(rows[i].e), 8'(output_enable));
        end
        cmd(1'b0, 8'hf8, 8'h80);
        meas(HI);
        meas(LO);
        cmd(1'b0, 8'hf8, 8'hb8);
        check("sticky", 8'h01, 8'(status_mon_ov_fault));
        check("latched", 8'h00, 8'(output_enable));
        cmd(1'b0, 8'h03, 8'h00);
        check("cleared", 8'h00, 8'(status_mon_ov_fault));
        meas(HI);
        repeat (30) @(posedge clk_sys);
        #1 check("retry_hi", 8'h00, 8'(output_enable));
        meas(LO);
        repeat (2) @(posedge clk_sys);
        #1 check("retry_lo", 8'h01, 8'(output_enable));
        cmd(1'b0, 8'hf8, 8'hbf);
        meas(HI);
        meas(LO);
        for (n = 2; !output_enable && n < 200; n++) @(posedge clk_sys) #1;
        check("gap", 8'd80, 8'(n));
        cmd(1'b0, 8'hf8, 8'hc0);
        meas(HI);
        meas(16'd3892);
        @(posedge clk_sys) #1 check("hold", 8'h00, 8'(output_enable));
        meas(16'd3891);
        @(posedge clk_sys) #1 check("resume", 8'h01, 8'(output_enable));
        cmd(1'b0, 8'h03, 8'h00);
        meas(16'd3686);
        check("warn_lo", 8'h00, 8'(status_mon_ov_warn));
        meas(16'd3687);
        check("warn_hi", 8'h01, 8'(status_mon_ov_warn));
        cmd(1'b0, 8'hf8, 8'hbf);
        meas(HI);
        other_fault_off = 1'b1;
        meas(LO);
        repeat (100) @(posedge clk_sys);
        #1 check("stopped", 8'h00, 8'(output_enable));
        other_fault_off = 1'b0;
        cmd(1'b0, 8'h03, 8'h00);
        check("restart", 8'h01, 8'(output_enable));
        wrap_up();
    end
endmodule : test_monitor_ov_fault_response
`default_nettype wire
